// ---- rtl/option_loader_defs.svh ----
// Offsets, field positions and reset values for the option byte loader.
`ifndef OPTION_LOADER_DEFS_SVH
`define OPTION_LOADER_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte offsets on the Avalon-MM slave
// ----------------------------------------------------------------------
`define OPT_REG_OPTIONS    4'h0
`define OPT_REG_STATUS     4'h4
`define OPT_REG_WDOG_CTRL  4'h8

// ----------------------------------------------------------------------
// Option byte field positions
// ----------------------------------------------------------------------
`define OPT_BIT_PROTECT    0
`define OPT_BIT_OSCILLATOR_TYPE_BIT      1
`define OPT_BIT_DEV        2
`define OPT_BIT_NMI_PULL   3
`define OPT_BIT_TIMER_PIN_PULLUP_BIT   4
`define OPT_BIT_WATCHDOG_HW_ACTIVATION_BIT      5
`define OPT_BIT_OSC_SAFEGUARD_ENABLE_BIT      6

// ----------------------------------------------------------------------
// Status register field positions
// ----------------------------------------------------------------------
`define STAT_BIT_LOADED    0
`define STAT_BIT_PROG      1
`define STAT_BIT_RUN       2
`define STAT_BIT_WDOG_ON   3

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define OPT_RESET_VALUE    8'h00
`define PROT_READ_VALUE    8'hFF
`define BUS_ZERO           32'h0000_0000

`endif

// ---- rtl/option_loader_pkg.sv ----
// Types shared by the option byte loader and its bench.
package option_loader_pkg;

   // -------------------------------------------------------------------
   // Loader sequence states
   // -------------------------------------------------------------------
   typedef enum logic [2:0] {
      ld_fetch,
      ld_wait,
      ld_hold,
      ld_run,
      ld_prog
   } loader_state_e;

   // -------------------------------------------------------------------
   // Option byte as fields, bit 7 down to bit 0
   // -------------------------------------------------------------------
   typedef struct packed {
      logic spare;
      logic osc_safeguard_enable_bit;
      logic watchdog_hw_activation_bit;
      logic timer_pin_pullup_bit;
      logic nmi_pin_pullup_bit;
      logic package_variant_bit;
      logic oscillator_type_bit;
      logic readout_protect_bit;
   } option_byte_s;

   // -------------------------------------------------------------------
   // Pin and pad configuration applied from the option byte
   // -------------------------------------------------------------------
   typedef struct packed {
      logic nmi_pullup_en;
      logic timer_pullup_en;
      logic osc_crystal_sel;
      logic readout_block;
      logic watchdog_hw_en;
      logic oscillator_safeguard;
   } pad_config_s;

endpackage : option_loader_pkg

// ---- rtl/option_byte_mode_loader.sv ----
// Power-up option byte loader and operating mode selector.
`timescale 1ns/1ps
`include "option_loader_defs.svh"

module option_byte_mode_loader #(
   parameter int UNBONDED_LINES = 8
) (
   // Clock and power-on reset
   input  wire logic                      core_clk,
   input  wire logic                      resetn,
   // Pins from outside the clock domain
   input  wire logic                      reset_pin_n,
   input  wire logic                      test_hv_detect,
   // Option byte storage port
   output logic                           nvm_opt_req,
   input  wire logic                      nvm_opt_valid,
   input  wire logic [7:0]                nvm_opt_data,
   // External program memory readout path
   input  wire logic                      mem_rd_valid,
   input  wire logic [7:0]                mem_rd_data,
   output logic                           ext_rd_valid,
   output logic [7:0]                     ext_rd_data,
   // Core control
   output logic                           core_reset_n,
   output logic                           core_start,
   output logic                           prog_mode,
   // Pad and clock configuration
   output option_loader_pkg::pad_config_s pad_cfg,
   output logic                           test_pulldown_en,
   output logic [UNBONDED_LINES-1:0]      unbonded_tie_hi,
   // Avalon-MM slave
   input  wire logic [3:0]                avs_address,
   input  wire logic                      avs_read,
   input  wire logic                      avs_write,
   input  wire logic [31:0]               avs_writedata,
   output logic [31:0]                    avs_readdata,
   output logic                           avs_waitrequest
);

   // -------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------
   option_loader_pkg::loader_state_e state;
   option_loader_pkg::loader_state_e next_state;
   option_loader_pkg::option_byte_s  opt;
   logic                             loaded;
   logic                             rst_meta;
   logic                             rst_sync;
   logic                             test_meta;
   logic                             test_sync;
   logic                             sw_wdog_on;
   logic                             bus_ack;
   logic                             core_run;
   logic                             entering_run;
   logic                             opt_capture;
   logic                             wdog_active;
   logic                             bus_req;
   logic                             hit_options;
   logic                             hit_status;
   logic                             hit_wdog;
   logic                             wdog_wr;
   logic [31:0]                      next_readdata;
   logic [31:0]                      status_word;

   // -------------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------------
   // The reset pin and the high-voltage detector are both asynchronous
   // to the core clock, so each passes two flops before use.  The reset
   // pin synchroniser resets low so the core stays held until the pin
   // has been seen high twice after power-up.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta  <= 1'b0;
         rst_sync  <= 1'b0;
         test_meta <= 1'b0;
         test_sync <= 1'b0;
      end else begin
         rst_meta  <= reset_pin_n;
         rst_sync  <= rst_meta;
         test_meta <= test_hv_detect;
         test_sync <= test_meta;
      end
   end

   // The pad pull-down stays on at all times; a floating test pin then
   // reads as low and the part comes up in normal mode.
   assign test_pulldown_en = 1'b1;

   // -------------------------------------------------------------------
   // Loader sequence
   // -------------------------------------------------------------------
   // The fetch runs only after power-on reset, without any software.
   // The reset pin only reopens the hold state, so the option byte is
   // never fetched twice within one power cycle.
   always_comb begin
      next_state = state;
      case (state)
         option_loader_pkg::ld_fetch: begin
            next_state = option_loader_pkg::ld_wait;
         end
         option_loader_pkg::ld_wait: begin
            if (nvm_opt_valid) begin
               next_state = option_loader_pkg::ld_hold;
            end
         end
         option_loader_pkg::ld_hold: begin
            // The test level is judged at the end of the reset phase.
            if (rst_sync && test_sync) begin
               next_state = option_loader_pkg::ld_prog;
            end else if (rst_sync) begin
               next_state = option_loader_pkg::ld_run;
            end
         end
         option_loader_pkg::ld_run: begin
            if (!rst_sync) begin
               next_state = option_loader_pkg::ld_hold;
            end
         end
         option_loader_pkg::ld_prog: begin
            if (!rst_sync) begin
               next_state = option_loader_pkg::ld_hold;
            end
         end
         default: begin
            next_state = option_loader_pkg::ld_fetch;
         end
      endcase
   end

   // State register.  An illegal code falls back to a fresh fetch, which
   // is harmless because the capture itself is guarded by the loaded flag.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state <= option_loader_pkg::ld_fetch;
      end else begin
         state <= next_state;
      end
   end

   // -------------------------------------------------------------------
   // Option byte capture
   // -------------------------------------------------------------------
   // The byte is taken once, the first time storage answers after
   // power-up, and then stays frozen; the programmer writes storage
   // only in programming mode and the new value waits for power-up.
   assign nvm_opt_req = (state == option_loader_pkg::ld_wait);
   assign opt_capture = nvm_opt_req && nvm_opt_valid && !loaded;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         opt    <= `OPT_RESET_VALUE;
         loaded <= 1'b0;
      end else if (opt_capture) begin
         opt    <= nvm_opt_data;
         loaded <= 1'b1;
      end
   end

   // -------------------------------------------------------------------
   // Core reset and restart
   // -------------------------------------------------------------------
   // The core leaves reset only after options are in force, so the
   // first instruction already sees the right clock and pad setup.
   // The start pulse marks a restart from the program's first address;
   // the core itself owns the vector fetch that follows.
   assign core_run     = (state == option_loader_pkg::ld_run);
   assign entering_run = (state == option_loader_pkg::ld_hold) &&
                         (next_state == option_loader_pkg::ld_run);

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         core_reset_n <= 1'b0;
         core_start   <= 1'b0;
         prog_mode    <= 1'b0;
      end else begin
         core_reset_n <= entering_run || (core_run && rst_sync);
         core_start   <= entering_run;
         prog_mode    <= (next_state == option_loader_pkg::ld_prog);
      end
   end

   // -------------------------------------------------------------------
   // Pad and oscillator configuration
   // -------------------------------------------------------------------
   // All fields follow the frozen byte; before the fetch they hold the
   // all-zero value, which is the safe RC, no pull-up, no block case.
   // The extra register stage costs one cycle after the capture but keeps
   // the pad drivers fed from flops only.
   assign wdog_active = opt.watchdog_hw_activation_bit || sw_wdog_on;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pad_cfg <= '0;
      end else begin
         pad_cfg.nmi_pullup_en        <= opt.nmi_pin_pullup_bit;
         pad_cfg.timer_pullup_en      <= opt.timer_pin_pullup_bit;
         pad_cfg.osc_crystal_sel      <= opt.oscillator_type_bit;
         pad_cfg.readout_block        <= opt.readout_protect_bit;
         pad_cfg.watchdog_hw_en       <=
            opt.watchdog_hw_activation_bit;
         pad_cfg.oscillator_safeguard <=
            opt.osc_safeguard_enable_bit;
      end
   end

   // Lines missing in the small package are tied high when the variant
   // bit is clear, so their input buffers never float.
   genvar gi;
   generate
      for (gi = 0; gi < UNBONDED_LINES; gi = gi + 1) begin : g_tie
         always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
               unbonded_tie_hi[gi] <= 1'b1;
            end else begin
               unbonded_tie_hi[gi] <= !opt.package_variant_bit;
            end
         end
      end
   endgenerate

   // -------------------------------------------------------------------
   // External readout gate
   // -------------------------------------------------------------------
   // With protection set the data bus shows a constant, so no content
   // leaks even while the programmer keeps clocking reads.
   // The gate also covers the span before the byte is loaded, when the
   // protect bit is not yet known.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ext_rd_valid <= 1'b0;
         ext_rd_data  <= `PROT_READ_VALUE;
      end else begin
         ext_rd_valid <= mem_rd_valid;
         if (opt.readout_protect_bit || !loaded) begin
            ext_rd_data <= `PROT_READ_VALUE;
         end else begin
            ext_rd_data <= mem_rd_data;
         end
      end
   end

   // -------------------------------------------------------------------
   // Avalon-MM slave
   // -------------------------------------------------------------------
   // Every access waits exactly one cycle; the answer is prepared in the
   // cycle the request first shows, and the write lands at the edge where
   // waitrequest is low.
   // A master that keeps its request up after the answer simply starts
   // a second access, which again waits one cycle.
   assign bus_req     = avs_read || avs_write;
   assign hit_options = (avs_address == `OPT_REG_OPTIONS);
   assign hit_status  = (avs_address == `OPT_REG_STATUS);
   assign hit_wdog    = (avs_address == `OPT_REG_WDOG_CTRL);
   assign wdog_wr     = avs_write && bus_ack && hit_wdog;
   assign avs_waitrequest = bus_req && !bus_ack;

   assign status_word = {28'h000_0000, wdog_active, core_run,
                         prog_mode, loaded};

   // Unmapped addresses read zero and ignore writes.
   assign next_readdata = hit_options ? {24'h00_0000, opt} :
                          hit_status  ? status_word :
                          hit_wdog    ? {31'h0000_0000, wdog_active} :
                          `BUS_ZERO;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         bus_ack      <= 1'b0;
         avs_readdata <= `BUS_ZERO;
      end else begin
         bus_ack <= bus_req && !bus_ack;
         if (avs_read && !bus_ack) begin
            avs_readdata <= next_readdata;
         end
      end
   end

   // Software watchdog start: once set it stays on until power-up, and
   // a zero write cannot stop it, which is the usual watchdog hazard.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         sw_wdog_on <= 1'b0;
      end else if (wdog_wr && avs_writedata[0]) begin
         sw_wdog_on <= 1'b1;
      end
   end

endmodule : option_byte_mode_loader

// ---- sim/option_loader_chk.sv ----
// Port checker for the option byte loader.
`timescale 1ns/1ps
module option_loader_chk #(
   parameter int UNBONDED_LINES = 8
) (
   // Clock, resets and pins
   input wire logic                           core_clk,
   input wire logic                           resetn,
   input wire logic                           reset_pin_n,
   // Option fetch and readout
   input wire logic                           nvm_opt_req,
   input wire logic                           nvm_opt_valid,
   input wire logic [7:0]                     nvm_opt_data,
   input wire logic                           mem_rd_valid,
   input wire logic [7:0]                     mem_rd_data,
   input wire logic                           ext_rd_valid,
   input wire logic [7:0]                     ext_rd_data,
   // Core control and pads
   input wire logic                           core_reset_n,
   input wire logic                           core_start,
   input wire logic                           prog_mode,
   input wire option_loader_pkg::pad_config_s pad_cfg,
   input wire logic                           test_pulldown_en,
   input wire logic [UNBONDED_LINES-1:0]      unbonded_tie_hi,
   // Bus handshake
   input wire logic                           avs_read,
   input wire logic                           avs_write,
   input wire logic                           avs_waitrequest
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   option_loader_pkg::pad_config_s want_pad;
   logic                           fetch_d1;
   // Pad image that the byte on the fetch port should give.
   assign want_pad = {nvm_opt_data[3], nvm_opt_data[4], nvm_opt_data[1],
                      nvm_opt_data[0], nvm_opt_data[5], nvm_opt_data[6]};
   // Marks the one edge at which the pads may legally move.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) fetch_d1 <= 1'b0;
      else fetch_d1 <= nvm_opt_req && nvm_opt_valid;
   end
   sequence fetch_s;
      nvm_opt_req && nvm_opt_valid;
   endsequence
   sequence bus_s;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   AST_FETCH_DROP:
      assert property (fetch_s |=> !nvm_opt_req)
      else $error("Option request held after capture.");
   AST_PAD_APPLY:
      assert property (fetch_s |-> ##2 pad_cfg == $past(want_pad, 2))
      else $error("Pad setup differs from option byte.");
   AST_TIE_HIGH:
      assert property (fetch_s |-> ##2
         unbonded_tie_hi == {UNBONDED_LINES{!$past(nvm_opt_data[2], 2)}})
      else $error("Unbonded tie wrong for variant bit.");
   AST_PAD_HOLD:
      assert property (!fetch_d1 |=> $stable(pad_cfg))
      else $error("Pad setup moved without a fetch.");
   AST_PIN_HOLD:
      assert property (!reset_pin_n [*5] |-> !core_reset_n && !prog_mode)
      else $error("Core not held while reset pin low.");
   AST_START_PULSE:
      assert property ($rose(core_reset_n) |-> core_start ##1 !core_start)
      else $error("Start pulse missing or too long.");
   AST_MODE_EXCL:
      assert property (!(prog_mode && core_reset_n))
      else $error("Programming and run at once.");
   AST_PULLDOWN:
      assert property (test_pulldown_en)
      else $error("Test pin pull-down off.");
   AST_READ_PROT:
      assert property (mem_rd_valid && prog_mode |=> ext_rd_valid &&
         ext_rd_data == ($past(pad_cfg.readout_block) ? 8'hFF
                                                      : $past(mem_rd_data)))
      else $error("Readout data wrong for protect setting.");
   AST_BUS_ACK:
      assert property (bus_s |=> !avs_waitrequest)
      else $error("Bus access not answered after one wait.");
endmodule : option_loader_chk

bind option_byte_mode_loader option_loader_chk #(
   .UNBONDED_LINES(UNBONDED_LINES)
) i_option_loader_chk (
   .core_clk, .resetn, .reset_pin_n, .nvm_opt_req, .nvm_opt_valid,
   .nvm_opt_data, .mem_rd_valid, .mem_rd_data, .ext_rd_valid,
   .ext_rd_data, .core_reset_n, .core_start, .prog_mode, .pad_cfg,
   .test_pulldown_en, .unbonded_tie_hi, .avs_read, .avs_write,
   .avs_waitrequest
);

// ---- sim/opt_store_model.sv ----
// Model of the option byte storage as left by the programmer.
`timescale 1ns/1ps
module opt_store_model (
   // Clock and fetch handshake
   input wire logic       core_clk,
   input wire logic       nvm_opt_req,
   output logic           nvm_opt_valid,
   output logic [7:0]     nvm_opt_data,
   // Byte written in programming mode and answer delay
   input wire logic [7:0] stored_byte,
   input wire logic [3:0] delay
);
   logic [3:0] wait_cnt = 4'h0;
   initial nvm_opt_valid = 1'b0;
   initial nvm_opt_data = 8'h00;
   // Answer after the delay; data toggles when idle so a late capture fails.
   always @(posedge core_clk) begin
      if (nvm_opt_req && !nvm_opt_valid && wait_cnt >= delay) begin
         nvm_opt_valid <= 1'b1;
         nvm_opt_data <= stored_byte;
         wait_cnt <= 4'h0;
      end else if (nvm_opt_req && !nvm_opt_valid) begin
         wait_cnt <= wait_cnt + 4'h1;
      end else begin
         nvm_opt_valid <= 1'b0;
         nvm_opt_data <= ~nvm_opt_data;
         wait_cnt <= 4'h0;
      end
   end
endmodule : opt_store_model

// ---- sim/tb_top.sv ----
// Self-checking bench for the option byte loader.
`timescale 1ns/1ps
`include "option_loader_defs.svh"
module tb_top;
   typedef struct {
      logic [7:0] opt;
      logic       hv;
      logic [3:0] lat;
      logic [5:0] pad;
      logic       tie;
   } row_s;
   logic        core_clk = 1'b0, resetn = 1'b0, reset_pin_n = 1'b1;
   logic        test_hv_detect = 1'b0, nvm_opt_req, nvm_opt_valid;
   logic        mem_rd_valid = 1'b0, ext_rd_valid, core_reset_n;
   logic        core_start, prog_mode, test_pulldown_en;
   logic        avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
   logic [3:0]  avs_address = 4'h0, lat = 4'h0;
   logic [7:0]  nvm_opt_data, mem_rd_data = 8'h00, ext_rd_data;
   logic [7:0]  stored = 8'h00, unbonded_tie_hi;
   logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, rd;
   int          bad_count = 0, checks_done = 0, starts = 0;
   option_loader_pkg::pad_config_s pad_cfg;
   row_s        rows [4] = '{'{8'h00, 1'b0, 4'h0, 6'h00, 1'b1},
                             '{8'h7F, 1'b0, 4'h3, 6'h3F, 1'b0},
                             '{8'h2A, 1'b1, 4'h6, 6'h2A, 1'b1},
                             '{8'h55, 1'b1, 4'h1, 6'h15, 1'b0}};

   always #5 core_clk = ~core_clk;
   // Counts start pulses so restarts can be tallied at the end.
   always @(posedge core_clk) if (core_start === 1'b1) starts <= starts + 1;

   option_byte_mode_loader #(.UNBONDED_LINES(8)) i_option_byte_mode_loader (
      .core_clk, .resetn, .reset_pin_n, .test_hv_detect, .nvm_opt_req,
      .nvm_opt_valid, .nvm_opt_data, .mem_rd_valid, .mem_rd_data,
      .ext_rd_valid, .ext_rd_data, .core_reset_n, .core_start, .prog_mode,
      .pad_cfg, .test_pulldown_en, .unbonded_tie_hi, .avs_address,
      .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);
   opt_store_model i_opt_store_model (.core_clk, .nvm_opt_req,
      .nvm_opt_valid, .nvm_opt_data, .stored_byte(stored), .delay(lat));

   // ------------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      checks_done++;
      if (seen !== want) begin
         bad_count++;
         $display("CHECK FAILED at %0t: saw %h expected %h",
                  $time, seen, want);
      end
   endtask : chk

   // Holds the request until waitrequest is sampled low at a rising edge,
   // takes the read data at that same edge and only then releases it.
   // A slave that never answers is cut short by the watchdog below.
   task automatic bus(input logic wr, input logic [3:0] a,
                      input logic [31:0] wd);
      @(posedge core_clk);
      avs_read <= !wr;
      avs_write <= wr;
      avs_address <= a;
      avs_writedata <= wd;
      do begin
         @(posedge core_clk);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus

   task automatic rdchk(input logic [3:0] a, input logic [31:0] want);
      bus(1'b0, a, 32'h0000_0000);
      chk(rd, want);
   endtask : rdchk

   task automatic wait_mode();
      int n;
      n = 0;
      do begin @(negedge core_clk); n++; end
      while (core_reset_n !== 1'b1 && prog_mode !== 1'b1 && n < 50);
      if (n >= 50) bad_count++;
   endtask : wait_mode

   task automatic tally_and_finish();
      $display("Checks made %0d, mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : tally_and_finish

   // ------------------------------------------------------------------
   // Sequence: one power-up per row, then warm reset and registers
   // ------------------------------------------------------------------
   initial begin
      foreach (rows[i]) begin
         @(posedge core_clk);
         resetn <= 1'b0;
         stored <= rows[i].opt;
         lat <= rows[i].lat;
         test_hv_detect <= rows[i].hv;
         repeat (2) @(posedge core_clk);
         chk(ext_rd_data, 8'hFF);
         chk(unbonded_tie_hi, 8'hFF);
         chk(core_reset_n, 1'b0);
         chk(test_pulldown_en, 1'b1);
         resetn <= 1'b1;
         wait_mode();
         chk(pad_cfg, rows[i].pad);
         chk(unbonded_tie_hi, {8{rows[i].tie}});
         chk(prog_mode, rows[i].hv);
         chk(core_reset_n, !rows[i].hv);
         @(posedge core_clk);
         mem_rd_valid <= 1'b1;
         mem_rd_data <= 8'hC3;
         @(posedge core_clk);
         mem_rd_valid <= 1'b0;
         @(negedge core_clk);
         chk({ext_rd_valid, ext_rd_data},
             {1'b1, rows[i].opt[0] ? 8'hFF : 8'hC3});
         rdchk(`OPT_REG_OPTIONS, {24'h00_0000, rows[i].opt});
         rdchk(`OPT_REG_STATUS, {28'h000_0000, rows[i].opt[5],
               !rows[i].hv, rows[i].hv, 1'b1});
      end
      // Warm reset must restart without fetching the new stored byte.
      @(posedge core_clk);
      test_hv_detect <= 1'b0;
      reset_pin_n <= 1'b0;
      stored <= 8'h7F;
      repeat (6) @(posedge core_clk);
      chk(prog_mode, 1'b0);
      chk(nvm_opt_req, 1'b0);
      reset_pin_n <= 1'b1;
      wait_mode();
      chk(core_reset_n, 1'b1);
      chk(pad_cfg, 6'h15);
      @(posedge core_clk);
      test_hv_detect <= 1'b1;
      repeat (8) @(posedge core_clk);
      chk(prog_mode, 1'b0);
      chk(starts, 3);
      rdchk(`OPT_REG_WDOG_CTRL, 32'h0000_0000);
      bus(1'b1, `OPT_REG_WDOG_CTRL, 32'h0000_0001);
      rdchk(`OPT_REG_WDOG_CTRL, 32'h0000_0001);
      bus(1'b1, `OPT_REG_OPTIONS, 32'hFFFF_FFFF);
      rdchk(`OPT_REG_OPTIONS, 32'h0000_0055);
      rdchk(4'hC, 32'h0000_0000);
      tally_and_finish();
   end

   // Cuts a hang short; the whole run needs well under a thousand cycles.
   initial begin
      #100000;
      bad_count++;
      tally_and_finish();
   end
endmodule : tb_top
